// *** bench/i2c_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bus host, 400 ns link clock
// ----------------------------------------
module i2c_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
	input logic clk,
	input logic sda_oe,
	output logic scl,
	output wire logic sda
);
	logic drv = 1'b1; // Host data drive, 1 = released
	logic [7:0] r; // Scratch byte
	logic a1, a2, a3; // Acknowledge bits
	// Link clock stands high outside frames
	initial scl = 1'b1;
	// Pull-up wins unless a party pulls low
	assign sda = drv & ~sda_oe;
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	// Data moves mid-low so it never looks like a start or stop
	task automatic bitio(input logic b, output logic s);
		drv = b;
		wt(2);
		scl = 1'b1;
		wt(4);
		s = sda;
		scl = 1'b0;
		wt(2);
	endtask : bitio
	task automatic start();
		drv = 1'b1;
		wt(2);
		scl = 1'b1;
		wt(2);
		drv = 1'b0;
		wt(4);
		scl = 1'b0;
		wt(2);
	endtask : start
	task automatic stop();
		drv = 1'b0;
		wt(2);
		scl = 1'b1;
		wt(4);
		drv = 1'b1;
		wt(4);
	endtask : stop
	// Eight bits MSB first, then the acknowledge slot
	task automatic byteio(input logic [7:0] w, input logic m, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bitio(w[i], q[i]);
		end
		bitio(m, k);
	endtask : byteio
	task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] x, output logic k);
		start();
		byteio({ad, 1'b0}, 1'b1, r, a1);
		byteio(p, 1'b1, r, a2);
		byteio(x, 1'b1, r, a3);
		stop();
		k = a1 | a2 | a3;
	endtask : wr
	// Pointer write, repeated start, one byte, no-ack
	task automatic rd(input logic [7:0] p, output logic [7:0] x);
		start();
		byteio({DEV_ADDR, 1'b0}, 1'b1, r, a1);
		byteio(p, 1'b1, r, a2);
		start();
		byteio({DEV_ADDR, 1'b1}, 1'b1, r, a3);
		byteio(8'hFF, 1'b1, x, a1);
		stop();
	endtask : rd
endmodule : i2c_host_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic clk = 0, rst_n = 0, dv = 0, lf = 0, rf = 0, cd = 0, ic = 0, pw = 0, mw = 0, k;
	logic [1:0] ch = 0;
	logic [2:0] pd = 0, md = 0;
	logic [6:0] tt = 7'h20, nt = 7'h10;
	logic [7:0] d = 0, v;
	logic [7:0] adr [4] = '{8'h20, 8'h21, 8'h22, 8'h44};
	logic [7:0] msk [4] = '{8'hB8, 8'h07, 8'hFF, 8'hFD};
	logic [7:0] rm [4] = '{8'h20, 8'h07, 8'hA4, 8'h40};
	wire scl, sda, soe, dov, rs, sst, fp, io, ioe, lme;
	wire [7:0] dout;
	wire [1:0] doc;
	wire [2:0] rr, ns, ts, lm, se, lt;
	int n_errors = 0, n_compared = 0, c, g, b, n;
	// Short ms tick keeps timer scenarios within the run
	touch_sensor_global_config #(.MS_TICK_CYCLES(20), .STALL_LOW_CYCLES(200), .SAMPLE_CYCLE_MS(5)) i_dut (
		.CLK_SYS(clk), .RESET_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(soe),
		.DELTA_IN_VALID(dv), .DELTA_IN_CH(ch), .DELTA_IN(d), .LF_NOISE_IN(lf), .RF_NOISE_IN(rf),
		.TOUCH_THRESH(tt), .NOISE_THRESH(nt), .AUTO_REPEAT_EN(3'h0), .CONV_DONE(cd), .IRQ_CLEAR(ic),
		.LED_POL_WR(pw), .LED_POL_DATA(pd), .LED_MIR_WR(mw), .LED_MIR_DATA(md), .DELTA_OUT(dout),
		.DELTA_OUT_VALID(dov), .DELTA_OUT_CH(doc), .RECAL_SAMPLE(rs), .RECAL_RESTART(rr), .NOISE_STATUS(ns),
		.TOUCH_STATUS(ts), .SAMPLE_START(sst), .SCAN_EN(se), .FRONTEND_PWR(fp), .IRQ_OUT(io), .IRQ_OE(ioe),
		.LED_TOUCH(lt), .LINK_MINMAX_EQUAL(lme), .LED_MIRROR(lm));
	i2c_host_model i_host (.clk(clk), .sda_oe(soe), .scl(scl), .sda(sda));
	initial forever #25 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic conclude();
		if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	// One sample; result stands next cycle
	task automatic send(input logic [1:0] h, input logic [7:0] x, input logic l, input logic r);
		@(negedge clk);
		{dv, ch, d, lf, rf} = {1'b1, h, x, l, r};
		@(negedge clk);
		dv = 1'b0;
	endtask : send
	task automatic pulse(input int s, input logic [2:0] x);
		{ic, pw, mw, cd, pd, md} = {s == 0, s == 1, s == 2, s == 3, x, x};
		@(negedge clk);
		{ic, pw, mw, cd} = 4'h0;
		@(negedge clk);
	endtask : pulse
	// Write here, expect acks
	task automatic w(input logic [7:0] p, input logic [7:0] x);
		i_host.wr(7'h2A, p, x, k);
		chk(k, 0);
	endtask : w
	// Hang guard
	initial begin
		repeat (90000) @(negedge clk);
		n_errors++;
		conclude();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h8774d6e8));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		i_host.wr(7'h15, 8'h21, 8'h00, k);
		chk(k, 1);
		for (int i = 0; i < 4; i++) begin
			i_host.rd(adr[i], v);
			chk(v, rm[i]);
			c = $urandom;
			w(adr[i], 8'(c));
			i_host.rd(adr[i], v);
			chk(v, 8'(c) & msk[i]);
		end
		i_host.rd(8'h30, v);
		chk(v, 8'h00);
		// Random gate settings, enables and samples
		for (int i = 0; i < 16; i++) begin
			c = $urandom;
			tt = 7'(c >> 8);
			nt = 7'(c >> 16);
			w(8'h21, 8'(c >> 4) & 8'h07);
			w(8'h20, {2'b00, c[0], c[1], 4'h0});
			w(8'h44, {4'h4, c[2], c[3], 2'b00});
			repeat (6) begin
				send(2'($urandom_range(2)), 8'($urandom), 1'($urandom), 1'($urandom));
				b = (lf && !c[1]) || (rf && !c[3]);
				g = b ? 0 : int'($signed(d));
				if (c[4 + ch]) begin
					chk({dov, doc}, {1'b1, ch});
					chk(dout, 8'(g));
					chk(rs, !b && g <= int'(tt) && (c[0] || g <= int'(nt)));
					chk(ns[ch], rf || (lf && !c[2]));
					chk(ts[ch], g > int'(tt));
				end else begin
					chk(dov, 0);
				end
			end
		end
		// Press and release interrupts, push-pull pin
		tt = 7'h20;
		w(8'h21, 8'h07);
		for (int j = 0; j < 2; j++) begin
			w(8'h44, j ? 8'h81 : 8'h00);
			chk(lme, !j);
			send(0, 0, 0, 0);
			pulse(0, 0);
			send(0, 8'h7F, 0, 0);
			chk({io, ioe}, 2'b11);
			chk(lt[0], !j);
			pulse(0, 0);
			send(0, 0, 0, 0);
			chk(io, !j);
			pulse(0, 0);
		end
		// Mirror follows polarity only while linked
		pulse(1, 3'h5);
		chk(lm, 5);
		w(8'h44, 8'h91);
		pulse(1, 3'h2);
		chk(lm, 5);
		pulse(2, 3'h3);
		chk(lm, 3);
		// Front end after last conversion
		for (int j = 0; j < 2; j++) begin
			w(8'h44, j ? 8'hA0 : 8'h80);
			@(posedge sst);
			@(negedge clk);
			chk(se, 7);
			pulse(3, 0);
			chk(fp, 8'(j));
		end
		// Long hold: shortest limit, 560 ticks of 20 clocks
		w(8'h22, 8'h0F);
		w(8'h20, 8'h28);
		send(0, 0, 0, 0);
		send(0, 8'h7F, 0, 0);
		for (n = 0; !rr[0] && n < 12000; n++) @(negedge clk);
		chk(n > 11150 && n < 11230, 1);
		conclude();
	end
endmodule : tb_top

// *** bench/touch_cfg_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checks of the config block
// ----------------------------------------
module touch_cfg_props import touch_cfg_pkg::*; #(
	parameter int MS_TICK_CYCLES = MS_TICK_CYCLES_DFLT,
	parameter int SAMPLE_CYCLE_MS = SAMPLE_CYCLE_MS_DFLT
) (
	input logic CLK_SYS,
	input logic RESET_N,
	input logic DELTA_IN_VALID,
	input logic [1:0] DELTA_IN_CH,
	input logic [7:0] DELTA_IN,
	input logic LF_NOISE_IN,
	input logic RF_NOISE_IN,
	input logic [6:0] TOUCH_THRESH,
	input logic [7:0] DELTA_OUT,
	input logic DELTA_OUT_VALID,
	input logic [1:0] DELTA_OUT_CH,
	input logic RECAL_SAMPLE,
	input logic [2:0] RECAL_RESTART,
	input logic [2:0] NOISE_STATUS,
	input logic SAMPLE_START,
	input logic FRONTEND_PWR,
	input logic IRQ_OUT,
	input logic IRQ_OE
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);
	localparam int PER = SAMPLE_CYCLE_MS * MS_TICK_CYCLES; // Cycle length in clocks
	int gap_ff; // Clocks since last cycle start
	// Spacing counter; -2 lines up the first cycle
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			gap_ff <= -2;
		end else if (SAMPLE_START) begin
			gap_ff <= 0;
		end else begin
			gap_ff <= gap_ff + 1;
		end
	end
	// Quiet sample passes unchanged
	property p_pass; DELTA_OUT_VALID && !$past(LF_NOISE_IN) && !$past(RF_NOISE_IN) |-> DELTA_OUT == $past(DELTA_IN); endproperty
	a_pass: assert property (p_pass) else $error("delta altered");
	property p_chan; DELTA_OUT_VALID |-> $past(DELTA_IN_VALID) && DELTA_OUT_CH == $past(DELTA_IN_CH); endproperty
	a_chan: assert property (p_chan) else $error("result channel");
	property p_recal; RECAL_SAMPLE |-> DELTA_OUT_VALID && $signed(DELTA_OUT) <= $signed({1'b0, $past(TOUCH_THRESH)}); endproperty
	a_recal: assert property (p_recal) else $error("touch used for recal");
	property p_clear; DELTA_OUT_VALID && !$past(LF_NOISE_IN) && !$past(RF_NOISE_IN) |-> !NOISE_STATUS[DELTA_OUT_CH]; endproperty
	a_clear: assert property (p_clear) else $error("noise flag sticky");
	property p_rf; DELTA_OUT_VALID && $past(RF_NOISE_IN) |-> NOISE_STATUS[DELTA_OUT_CH]; endproperty
	a_rf: assert property (p_rf) else $error("rf noise hidden");
	property p_irq; IRQ_OUT |-> IRQ_OE; endproperty
	a_irq: assert property (p_irq) else $error("irq pin undriven");
	property p_pwr; SAMPLE_START |-> ##[0:1] FRONTEND_PWR; endproperty
	a_pwr: assert property (p_pwr) else $error("front end off at start");
	property p_cycle; SAMPLE_START |-> gap_ff == PER - 1; endproperty
	a_cycle: assert property (p_cycle) else $error("cycle length");
	property p_pulse; RECAL_RESTART != 3'h0 |=> RECAL_RESTART == 3'h0; endproperty
	a_pulse: assert property (p_pulse) else $error("restart not a pulse");
	c_recal: cover property (RECAL_SAMPLE);
	c_restart: cover property (RECAL_RESTART[0]);
	c_irq: cover property ($rose(IRQ_OUT));
endmodule : touch_cfg_props
bind touch_sensor_global_config touch_cfg_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
	.SAMPLE_CYCLE_MS(SAMPLE_CYCLE_MS)) i_props (.*);

// *** logic/regbus_if.sv ***
`timescale 1ns/1ps
// Carrier between the serial port and the register bank
interface regbus_if;
	logic [7:0] addr; // Register pointer
	logic [7:0] wdata; // Write data
	logic wr_stb; // One-cycle write strobe
	logic [7:0] rdata; // Read data at pointer
	logic stall_guard_en; // Enables timeout and idle reset
	logic sda_oe; // Data line pull-down enable
	modport port (output addr, output wdata, output wr_stb, output sda_oe, input rdata, input stall_guard_en);
	modport bank (input addr, input wdata, input wr_stb, input sda_oe, output rdata, output stall_guard_en);
endinterface : regbus_if

// *** logic/smbus_target_port.sv ***
`timescale 1ns/1ps
module smbus_target_port import touch_cfg_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
	parameter int STALL_LOW_CYCLES = STALL_LOW_CYCLES_DFLT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	regbus_if.port bus
);
	typedef struct packed {
		port_state_t st;
		logic [3:0] bitcnt; // Bits done in byte
		logic [7:0] shreg; // Shift register
		logic [1:0] phase; // 0 address, 1 pointer, 2 data
		logic rw; // Read when set
		logic [7:0] ptr;
		logic scl_s1, scl_s2, scl_d;
		logic sda_s1, sda_s2, sda_d;
		logic sda_oe;
		logic [19:0] low_cnt; // Clock-low time
		logic [11:0] idle_cnt; // Both-high time
		logic wr_stb;
		logic [7:0] wdata;
	} port_t;
	port_t r, n;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [7:0] byte_in;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.wr_stb = 1'b0;
		// Two-flop sync; only stage 2 onward is decoded
		n.scl_s1 = scl_pin;
		n.scl_s2 = r.scl_s1;
		n.scl_d = r.scl_s2;
		n.sda_s1 = sda_pin;
		n.sda_s2 = r.sda_s1;
		n.sda_d = r.sda_s2;
		scl_rise = r.scl_s2 & ~r.scl_d;
		scl_fall = ~r.scl_s2 & r.scl_d;
		start_cond = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
		stop_cond = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
		byte_in = {r.shreg[6:0], r.sda_s2};
		// Guard counters stay at zero when disabled
		if (bus.stall_guard_en && !r.scl_s2) begin
			n.low_cnt = (r.low_cnt == 20'hFFFFF) ? r.low_cnt : r.low_cnt + 20'h00001;
		end else begin
			n.low_cnt = 20'h00000;
		end
		if (bus.stall_guard_en && r.scl_s2 && r.sda_s2 && r.st != ST_IDLE) begin
			n.idle_cnt = (r.idle_cnt == 12'hFFF) ? r.idle_cnt : r.idle_cnt + 12'h001;
		end else begin
			n.idle_cnt = 12'h000;
		end
		case (r.st)
			ST_RECV: begin
				if (scl_rise) begin
					n.shreg = byte_in;
					n.bitcnt = r.bitcnt + 4'h1;
					if (r.bitcnt == 4'h7) begin
						n.st = ST_ACK_WAIT;
						if (r.phase == 2'd0) begin
							// Foreign address: drop out silently
							n.rw = byte_in[0];
							n.phase = byte_in[0] ? 2'd2 : 2'd1;
							if (byte_in[7:1] != DEV_ADDR) n.st = ST_IDLE;
						end else if (r.phase == 2'd1) begin
							n.ptr = byte_in;
							n.phase = 2'd2;
						end else begin
							n.wdata = byte_in;
							n.wr_stb = 1'b1;
						end
					end
				end
			end
			ST_ACK_WAIT: begin
				if (scl_fall) begin
					n.sda_oe = 1'b1;
					n.st = ST_ACK_HOLD;
				end
			end
			ST_ACK_HOLD: begin
				// Also entered after a master ack on reads
				if (scl_fall) begin
					n.bitcnt = 4'h0;
					if (r.rw) begin
						n.shreg = bus.rdata;
						n.sda_oe = ~bus.rdata[7];
						n.st = ST_SEND;
					end else begin
						n.sda_oe = 1'b0;
						n.st = ST_RECV;
					end
				end
			end
			ST_SEND: begin
				if (r.bitcnt == 4'h8) begin
					// Master ack bit: nack ends the read
					if (scl_rise) n.st = r.sda_s2 ? ST_IDLE : ST_ACK_HOLD;
				end else if (scl_fall) begin
					n.bitcnt = r.bitcnt + 4'h1;
					n.shreg = {r.shreg[6:0], 1'b0};
					n.sda_oe = (r.bitcnt == 4'h7) ? 1'b0 : ~r.shreg[6];
				end
			end
			ST_IDLE: n.sda_oe = 1'b0;
			default: n.st = ST_IDLE;
		endcase
		if (start_cond) begin
			n.st = ST_RECV;
			n.bitcnt = 4'h0;
			n.phase = 2'd0;
			n.sda_oe = 1'b0;
		end
		if (stop_cond) begin
			n.st = ST_IDLE;
			n.sda_oe = 1'b0;
		end
		// Abort on stuck clock, reset on idle bus
		if (r.low_cnt >= 20'(STALL_LOW_CYCLES) || r.idle_cnt >= 12'(IDLE_HIGH_CYCLES)) begin
			n.st = ST_IDLE;
			n.sda_oe = 1'b0;
			n.low_cnt = 20'h00000;
			n.idle_cnt = 12'h000;
		end
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end
	assign bus.addr = r.ptr;
	assign bus.wdata = r.wdata;
	assign bus.wr_stb = r.wr_stb;
	assign bus.sda_oe = r.sda_oe;
endmodule : smbus_target_port

// *** logic/touch_cfg_pkg.sv ***
package touch_cfg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h20;
	localparam logic [7:0] ADDR_CHANNEL_SAMPLE_ENABLE = 8'h21;
	localparam logic [7:0] ADDR_HOLD_AND_REPEAT_TIMING = 8'h22;
	localparam logic [7:0] ADDR_GLOBAL_CONFIG_SECOND = 8'h44;
	localparam logic [7:0] RST_GLOBAL_CONFIG_REV_B = 8'hA0;
	localparam logic [7:0] RST_GLOBAL_CONFIG_REV_C = 8'h20;
	localparam logic [7:0] RST_CHANNEL_SAMPLE_ENABLE = 8'h07;
	localparam logic [7:0] RST_HOLD_AND_REPEAT_TIMING = 8'hA4;
	localparam logic [7:0] RST_GLOBAL_CONFIG_SECOND = 8'h40;
	localparam logic [7:0] MASK_GLOBAL_CONFIG = 8'hB8;
	localparam logic [7:0] MASK_CHANNEL_SAMPLE_ENABLE = 8'h07;
	localparam logic [7:0] MASK_HOLD_AND_REPEAT_TIMING = 8'hFF;
	localparam logic [7:0] MASK_GLOBAL_CONFIG_SECOND = 8'hFD;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_STALL_GUARD = 7;
	localparam int BIT_DIGITAL_NOISE_GATE_OFF = 5;
	localparam int BIT_LOWFREQ_NOISE_FILTER_OFF = 4;
	localparam int BIT_LONG_HOLD_RECAL_EN = 3;
	localparam int BIT_LINKED_TRANSITION_INVERT = 7;
	localparam int BIT_IRQ_PIN_POLARITY = 6;
	localparam int BIT_KEEP_SENSOR_POWERED = 5;
	localparam int BIT_POLARITY_MIRROR_UNLINK = 4;
	localparam int BIT_RF_ONLY_NOISE_REPORT = 3;
	localparam int BIT_RF_NOISE_FILTER_OFF = 2;
	localparam int BIT_NO_RELEASE_IRQ = 0;
	localparam int LONG_HOLD_LIMIT_LSB = 4;
	localparam int REPEAT_INTERVAL_LSB = 0;
	localparam int NUM_CH = 3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_TICK_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
	localparam int STALL_LOW_MS = 30;
	localparam int STALL_LOW_CYCLES_DFLT = STALL_LOW_MS * MS_TICK_CYCLES_DFLT;
	localparam int IDLE_HIGH_US = 200;
	localparam int IDLE_HIGH_CYCLES = (IDLE_HIGH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPEAT_STEP_MS = 35;
	localparam int SAMPLE_CYCLE_MS_DFLT = 70;
	// ----------------------------------------
	// Serial port states
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_RECV = 5'h02, ST_ACK_WAIT = 5'h04, ST_ACK_HOLD = 5'h08, ST_SEND = 5'h10
	} port_state_t;
	// Long hold limit in ms, non-uniform steps
	function automatic logic [13:0] long_hold_ms(input logic [3:0] code);
		case (code)
			4'h0: long_hold_ms = 14'd560;
			4'h1: long_hold_ms = 14'd840;
			4'h2: long_hold_ms = 14'd1120;
			4'h3: long_hold_ms = 14'd1400;
			4'h4: long_hold_ms = 14'd1680;
			4'h5: long_hold_ms = 14'd2240;
			4'h6: long_hold_ms = 14'd2800;
			4'h7: long_hold_ms = 14'd3360;
			4'h8: long_hold_ms = 14'd3920;
			4'h9: long_hold_ms = 14'd4480;
			4'hA: long_hold_ms = 14'd5600;
			4'hB: long_hold_ms = 14'd6720;
			4'hC: long_hold_ms = 14'd7840;
			4'hD: long_hold_ms = 14'd8906;
			4'hE: long_hold_ms = 14'd10080;
			default: long_hold_ms = 14'd11200;
		endcase
	endfunction : long_hold_ms
	// Repeat spacing in ms, linear steps
	function automatic logic [9:0] repeat_ms(input logic [3:0] code);
		repeat_ms = 10'(({6'h00, code} + 10'h001) * 10'(REPEAT_STEP_MS));
	endfunction : repeat_ms
endpackage : touch_cfg_pkg

// *** logic/touch_sensor_global_config.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Guard off: no stall timeout, no idle reset
// - Guard on: 30ms clock-low abort, 200us idle reset
// - Guard reset value follows silicon revision
// - Digital gate on: noise-band deltas skip recal
// - Digital gate off: all unblocked sub-touch deltas recalibrate
// - Low-frequency noise zeroes delta unless filter off
// - Long hold on: recalibrate after limit
// - Long hold limit from fixed sixteen-entry table
// - Repeat spacing is code plus one times 35ms
// - Invert flips linked touch, else min equals max
// - Irq pin push-pull high or open-drain low
// - Front end sleeps unless kept powered
// - Polarity writes copy into mirror unless unlinked
// - Status shows RF only, or RF and LF
// - RF noise zeroes delta unless filter off
// - Release interrupts unless no-release bit set
// - Enable bits select channels; all on at reset
// - Cycle length ignores enabled count
// - Noise flags follow each sample, not sticky
module touch_sensor_global_config import touch_cfg_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
	parameter bit SILICON_REV_B = 1'b0, // Older silicon when set
	parameter int MS_TICK_CYCLES = MS_TICK_CYCLES_DFLT,
	parameter int STALL_LOW_CYCLES = STALL_LOW_CYCLES_DFLT,
	parameter int SAMPLE_CYCLE_MS = SAMPLE_CYCLE_MS_DFLT
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic DELTA_IN_VALID,
	input wire logic [1:0] DELTA_IN_CH,
	input wire logic [7:0] DELTA_IN,
	input wire logic LF_NOISE_IN,
	input wire logic RF_NOISE_IN,
	input wire logic [6:0] TOUCH_THRESH,
	input wire logic [6:0] NOISE_THRESH,
	input wire logic [2:0] AUTO_REPEAT_EN,
	input wire logic CONV_DONE,
	input wire logic IRQ_CLEAR,
	input wire logic LED_POL_WR,
	input wire logic [2:0] LED_POL_DATA,
	input wire logic LED_MIR_WR,
	input wire logic [2:0] LED_MIR_DATA,
	output logic [7:0] DELTA_OUT,
	output logic DELTA_OUT_VALID,
	output logic [1:0] DELTA_OUT_CH,
	output logic RECAL_SAMPLE,
	output logic [2:0] RECAL_RESTART,
	output logic [2:0] NOISE_STATUS,
	output logic [2:0] TOUCH_STATUS,
	output logic SAMPLE_START,
	output logic [2:0] SCAN_EN,
	output logic FRONTEND_PWR,
	output logic IRQ_OUT,
	output logic IRQ_OE,
	output logic [2:0] LED_TOUCH,
	output logic LINK_MINMAX_EQUAL,
	output logic [2:0] LED_MIRROR
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] global_config;
		logic [7:0] channel_sample_enable;
		logic [7:0] hold_and_repeat_timing;
		logic [7:0] global_config_second;
		logic [19:0] ms_div; // Clock cycles into current ms
		logic ms_tick; // One-cycle ms enable
		logic [7:0] cycle_ms; // Ms into sampling cycle
		logic sample_start;
		logic [2:0] scan_en;
		logic frontend_pwr;
		logic [2:0] touch;
		logic [2:0][13:0] hold_ms; // Touch duration
		logic [2:0][9:0] rpt_ms; // Time since last repeat
		logic [2:0] recal_restart;
		logic [2:0] noise;
		logic [7:0] delta_out;
		logic delta_valid;
		logic [1:0] delta_ch;
		logic recal_sample;
		logic irq_pend; // Pending interrupt level
		logic irq_out;
		logic irq_oe;
		logic [2:0] led_touch;
		logic minmax_eq;
		logic [2:0] mirror;
	} bank_t;
	bank_t r, n;
	regbus_if bus ();
	// Sample decode helpers
	logic [1:0] ch; // Channel of incoming sample
	logic ch_ok; // Sample on a sampled channel
	logic blocked; // Sample killed by noise filter
	logic [7:0] gated; // Delta after noise filters
	logic new_touch; // Above touch threshold
	logic noise_band; // Above noise threshold
	logic irq_event; // Any interrupt source this cycle
	// Field views
	logic guard_en, dig_gate_off, lf_off, long_hold_en;
	logic link_inv, irq_pol, keep_pwr, mir_unlink, rf_only, rf_off, no_rel;
	logic [3:0] limit_code, rpt_code;
	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	smbus_target_port #(
		.DEV_ADDR(DEV_ADDR),
		.STALL_LOW_CYCLES(STALL_LOW_CYCLES)
	) u_port (
		.clk(CLK_SYS),
		.rst_n(RESET_N),
		.scl_pin(SCL_IN),
		.sda_pin(SDA_IN),
		.bus(bus.port)
	);
	// Read mux; unmapped pointers read zero
	always_comb begin
		case (bus.addr)
			ADDR_GLOBAL_CONFIG: bus.rdata = r.global_config;
			ADDR_CHANNEL_SAMPLE_ENABLE: bus.rdata = r.channel_sample_enable;
			ADDR_HOLD_AND_REPEAT_TIMING: bus.rdata = r.hold_and_repeat_timing;
			ADDR_GLOBAL_CONFIG_SECOND: bus.rdata = r.global_config_second;
			default: bus.rdata = 8'h00;
		endcase
	end
	assign bus.stall_guard_en = guard_en;
	// Named views of the control fields
	assign guard_en = r.global_config[BIT_STALL_GUARD];
	assign dig_gate_off = r.global_config[BIT_DIGITAL_NOISE_GATE_OFF];
	assign lf_off = r.global_config[BIT_LOWFREQ_NOISE_FILTER_OFF];
	assign long_hold_en = r.global_config[BIT_LONG_HOLD_RECAL_EN];
	assign link_inv = r.global_config_second[BIT_LINKED_TRANSITION_INVERT];
	assign irq_pol = r.global_config_second[BIT_IRQ_PIN_POLARITY];
	assign keep_pwr = r.global_config_second[BIT_KEEP_SENSOR_POWERED];
	assign mir_unlink = r.global_config_second[BIT_POLARITY_MIRROR_UNLINK];
	assign rf_only = r.global_config_second[BIT_RF_ONLY_NOISE_REPORT];
	assign rf_off = r.global_config_second[BIT_RF_NOISE_FILTER_OFF];
	assign no_rel = r.global_config_second[BIT_NO_RELEASE_IRQ];
	assign limit_code = r.hold_and_repeat_timing[LONG_HOLD_LIMIT_LSB +: 4];
	assign rpt_code = r.hold_and_repeat_timing[REPEAT_INTERVAL_LSB +: 4];
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.ms_tick = 1'b0;
		n.sample_start = 1'b0;
		n.recal_restart = 3'h0;
		n.delta_valid = 1'b0;
		n.recal_sample = 1'b0;
		irq_event = 1'b0;
		// Register writes, reserved bits kept at zero
		if (bus.wr_stb) begin
			case (bus.addr)
				ADDR_GLOBAL_CONFIG: n.global_config = bus.wdata & MASK_GLOBAL_CONFIG;
				ADDR_CHANNEL_SAMPLE_ENABLE: n.channel_sample_enable = bus.wdata & MASK_CHANNEL_SAMPLE_ENABLE;
				ADDR_HOLD_AND_REPEAT_TIMING: n.hold_and_repeat_timing = bus.wdata & MASK_HOLD_AND_REPEAT_TIMING;
				ADDR_GLOBAL_CONFIG_SECOND: n.global_config_second = bus.wdata & MASK_GLOBAL_CONFIG_SECOND;
				default: ;
			endcase
		end
		// Millisecond timebase shared by the cycle, hold and repeat timers
		if (r.ms_div >= 20'(MS_TICK_CYCLES - 1)) begin
			n.ms_div = 20'h00000;
			n.ms_tick = 1'b1;
		end else begin
			n.ms_div = r.ms_div + 20'h00001;
		end
		// Fixed-length sampling cycle; the enable mask only gates channels
		if (r.ms_tick) begin
			if (r.cycle_ms >= 8'(SAMPLE_CYCLE_MS - 1)) begin
				n.cycle_ms = 8'h00;
				n.sample_start = 1'b1;
				n.scan_en = r.channel_sample_enable[2:0];
				n.frontend_pwr = 1'b1;
			end else begin
				n.cycle_ms = r.cycle_ms + 8'h01;
			end
		end
		// Sleep after the last conversion unless held on
		if (CONV_DONE && !n.sample_start) n.frontend_pwr = 1'b0;
		if (keep_pwr) n.frontend_pwr = 1'b1;
		// Incoming sample from the analog block
		ch = DELTA_IN_CH;
		ch_ok = DELTA_IN_VALID && (ch < 2'(NUM_CH)) && r.channel_sample_enable[ch];
		blocked = (LF_NOISE_IN && !lf_off) || (RF_NOISE_IN && !rf_off);
		gated = blocked ? 8'h00 : DELTA_IN;
		new_touch = $signed(gated) > $signed({1'b0, TOUCH_THRESH});
		noise_band = $signed(gated) > $signed({1'b0, NOISE_THRESH});
		if (ch_ok) begin
			n.delta_out = gated;
			n.delta_ch = ch;
			n.delta_valid = 1'b1;
			// Flag tracks this sample only; no latch
			n.noise[ch] = RF_NOISE_IN || (LF_NOISE_IN && !rf_only);
			// Recalibration sees only clean, sub-touch samples
			if (!blocked && !new_touch) begin
				n.recal_sample = dig_gate_off || !noise_band;
			end
			if (new_touch && !r.touch[ch]) begin
				n.touch[ch] = 1'b1;
				n.hold_ms[ch] = 14'h0000;
				n.rpt_ms[ch] = 10'h000;
				irq_event = 1'b1;
			end else if (!new_touch && r.touch[ch]) begin
				n.touch[ch] = 1'b0;
				if (!no_rel) irq_event = 1'b1;
			end
		end
		// Per-channel hold and repeat timers
		for (int i = 0; i < NUM_CH; i++) begin
			if (r.touch[i] && r.ms_tick && !(ch_ok && ch == 2'(i))) begin
				if (r.hold_ms[i] != 14'h3FFF) n.hold_ms[i] = r.hold_ms[i] + 14'h0001;
				// Held past the limit: restart recalibration once per limit
				if (long_hold_en && r.hold_ms[i] >= long_hold_ms(limit_code)) begin
					n.recal_restart[i] = 1'b1;
					n.hold_ms[i] = 14'h0000;
				end
				if (AUTO_REPEAT_EN[i]) begin
					if (r.rpt_ms[i] + 10'h001 >= repeat_ms(rpt_code)) begin
						n.rpt_ms[i] = 10'h000;
						irq_event = 1'b1;
					end else begin
						n.rpt_ms[i] = r.rpt_ms[i] + 10'h001;
					end
				end
			end
		end
		// Pending interrupt; a new event beats a clear
		if (IRQ_CLEAR) n.irq_pend = 1'b0;
		if (irq_event) n.irq_pend = 1'b1;
		// Pin drive: push-pull high or open-drain low
		if (irq_pol) begin
			n.irq_out = 1'b0;
			n.irq_oe = n.irq_pend;
		end else begin
			n.irq_out = n.irq_pend;
			n.irq_oe = 1'b1;
		end
		// Linked LED touch drive
		n.led_touch = n.touch ^ {3{link_inv}};
		n.minmax_eq = !link_inv;
		// Mirror bits; a linked polarity write wins over a direct one
		if (LED_MIR_WR) n.mirror = LED_MIR_DATA;
		if (LED_POL_WR && !mir_unlink) n.mirror = LED_POL_DATA;
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
			r.global_config <= SILICON_REV_B ? RST_GLOBAL_CONFIG_REV_B : RST_GLOBAL_CONFIG_REV_C;
			r.channel_sample_enable <= RST_CHANNEL_SAMPLE_ENABLE;
			r.hold_and_repeat_timing <= RST_HOLD_AND_REPEAT_TIMING;
			r.global_config_second <= RST_GLOBAL_CONFIG_SECOND;
			r.scan_en <= RST_CHANNEL_SAMPLE_ENABLE[2:0];
			r.minmax_eq <= 1'b1;
		end else begin
			r <= n;
		end
	end
	// ----------------------------------------
	// Outputs, all from flops except the constant SDA_OUT
	// ----------------------------------------
	assign SDA_OUT = 1'b0; // Open drain: only ever pulls low
	assign SDA_OE = bus.sda_oe;
	assign DELTA_OUT = r.delta_out;
	assign DELTA_OUT_VALID = r.delta_valid;
	assign DELTA_OUT_CH = r.delta_ch;
	assign RECAL_SAMPLE = r.recal_sample;
	assign RECAL_RESTART = r.recal_restart;
	assign NOISE_STATUS = r.noise;
	assign TOUCH_STATUS = r.touch;
	assign SAMPLE_START = r.sample_start;
	assign SCAN_EN = r.scan_en;
	assign FRONTEND_PWR = r.frontend_pwr;
	assign IRQ_OUT = r.irq_out;
	assign IRQ_OE = r.irq_oe;
	assign LED_TOUCH = r.led_touch;
	assign LINK_MINMAX_EQUAL = r.minmax_eq;
	assign LED_MIRROR = r.mirror;
endmodule : touch_sensor_global_config
